// *** hrs_counter.sv ***
// Purpose: down counter used for every timed interval of the sequencer
// Assumes: load takes priority over counting
// Notes:   done is high while the count is zero
`timescale 1ns/100ps
module hrs_counter
  import hrs_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // status
  output logic              done
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == '0);

endmodule

// *** hrs_partner.sv ***
// Purpose: reset supervisor and strap board facing the reset sequencer
// Assumes: board pull-up on the reset pin; straps are open or pulled down
// Notes:   open strap lines float (toggle) whenever the device pull-ups are off
`timescale 1ns/100ps
module hrs_partner
  import hrs_pkg::*;
#(
  parameter int unsigned MIN_LOW = 38
) (
  // clock
  input  wire logic             clk,
  // bench control
  input  wire logic             pull_req,
  input  wire logic [CFG_W-1:0] pulldown_mask,
  // device side
  input  wire logic             dev_oe,
  input  wire logic             dev_o,
  input  wire logic             pullup_en,
  output logic                  pin,
  output logic [CFG_W-1:0]      straps
);
  // power-up: the pin is held low for the minimum time from the first stable clock
  logic [7:0] low_cnt_q = 8'(MIN_LOW);
  logic       float_q   = 1'b0;

  // a short request still gets the full minimum low time
  always @(posedge clk) begin
    if (pull_req) begin
      low_cnt_q <= 8'(MIN_LOW);
    end else if (low_cnt_q != 8'h00) begin
      low_cnt_q <= low_cnt_q - 8'h01;
    end
    float_q <= ~float_q;
  end

  assign pin    = (pull_req || low_cnt_q != 8'h00 || (dev_oe && !dev_o)) ? 1'b0 : 1'b1;
  assign straps = ~pulldown_mask & (pullup_en ? {CFG_W{1'b1}} : {CFG_W{float_q}});
endmodule

// *** hrs_pkg.sv ***
// Purpose: shared constants and carriers for the hardware reset sequencer
// Assumes: one clock, 25 MHz; one half clock period counted per clock edge
// Notes:   counts are in half clock periods
package hrs_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned START_DLY_MIN   = 4;
  localparam int unsigned START_DLY_MAX   = 16;
  localparam int unsigned START_DLY       = 8;
  localparam int unsigned SEQ_LEN         = 1024;
  localparam int unsigned END_DLY_MIN     = 4;
  localparam int unsigned END_DLY_MAX     = 6;
  localparam int unsigned END_DLY         = 5;
  localparam int unsigned ALE_DLY         = 8;
  localparam int unsigned CNT_W           = 11;
  localparam int unsigned ADDR_W          = 24;
  localparam logic [23:0] RESET_VECTOR    = 24'h000000;
  localparam int unsigned CFG_W           = 16;
  localparam logic [15:0] CFG_RESET       = 16'hFFFF;

  typedef enum logic [2:0] {
    HRS_RUN      = 3'b000,
    HRS_ENTRY    = 3'b001,
    HRS_DRAIN    = 3'b010,
    HRS_SEQ      = 3'b011,
    HRS_WAIT_HI  = 3'b100,
    HRS_END      = 3'b101
  } hrs_state_t;

  typedef struct packed {
    logic        reset_active;
    logic        fetch_start;
    logic [23:0] fetch_addr;
  } hrs_core_t;

endpackage

// *** hrs_top.sv ***
// Purpose: hardware reset sequencer for cold and warm reset from the reset pin
// Assumes: reset pin input synchronous to CLK_SYS; one clock = one half clock period
// Notes:   reset pin is open drain: three signals, enable high while driving low
//
// Contract
// R1: enter default state as soon as reset input is asserted; RAM write may corrupt.
// R2: external party holds reset input low the required time after stable clock.
// R3: pull-ups on configuration port enabled during reset; open line reads one.
// R4: after reset, fetch and execution begin at address zero.
// R5: reset output stays asserted until end-of-initialization instruction executes.
// R6: I/O pins remain inactive after reset until software enables them.
// R7: warm reset cancels pending hold states, finishes current internal access first.
// R8: device drives its own reset pin low during the internal sequence.
// R9: reset ends only if the pin is sampled high after the sequence.
// R10: external party holds an asynchronous reset low at least 1500 ns.
// R11: internal sequence starts 4 to 16 half periods after reset pin falls.
// R12: internal reset ends 4 to 6 half periods after reset pin rises.
// R13: address latch enable rises exactly 8 half periods after internal reset end.
// R14: internal sequence lasts 1024 half periods, counted from its start; after SRST the code skips it (counter already zero).
`timescale 1ns/100ps
module hrs_top
  import hrs_pkg::*;
#(
  parameter int unsigned SEQ_CYCLES = SEQ_LEN
) (
  // clock and reset
  input  wire logic                CLK_SYS,
  input  wire logic                SRST,
  // reset pin, open drain
  input  wire logic                RESET_INPUT_N_I,
  output logic                     RESET_INPUT_N_O,
  output logic                     RESET_INPUT_N_OE,
  // reset output
  output logic                     RESET_OUTPUT_N,
  // core handshake
  input  wire logic                END_OF_INIT_INSTRUCTION,
  input  wire logic                ACCESS_BUSY,
  input  wire logic                HOLD_PENDING,
  input  wire logic                IO_ENABLE_SW,
  output logic                     CORE_RESET,
  output logic                     HOLD_CANCEL,
  output logic                     FETCH_START,
  output logic [ADDR_W-1:0]        FETCH_ADDR,
  output logic                     IO_ENABLE,
  output logic                     ALE,
  // start-up configuration port
  input  wire logic [CFG_W-1:0]    STARTUP_CONFIG_PORT,
  output logic                     CONFIG_PULLUP_EN,
  output logic [CFG_W-1:0]         STARTUP_CONFIG
);

  hrs_state_t state_q;
  hrs_core_t  core_q;
  logic       cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic       cnt_done;
  logic       ale_pend_q;
  logic       rout_n_q;
  logic       io_en_q;
  logic       pull_q;
  logic       drive_q;
  logic       hold_cancel_q;
  logic       ale_q;
  logic [CFG_W-1:0] cfg_q;

  hrs_counter #(.W(CNT_W)) u_cnt (
    .clk   (CLK_SYS),
    .srst  (SRST),
    .load  (cnt_load),
    .value (cnt_val),
    .done  (cnt_done)
  );

  // the pin is synchronous here, so "asynchronous" entry means the first edge that sees it low
  wire pin_low = !RESET_INPUT_N_I;

  always_comb begin
    cnt_load = 1'b0;
    cnt_val  = '0;
    case (state_q)
      HRS_RUN: begin
        if (pin_low) begin
          cnt_load = 1'b1;
          cnt_val  = CNT_W'(START_DLY - 1);  // see R11
        end
      end
      HRS_DRAIN: begin
        if (cnt_done && !ACCESS_BUSY) begin
          cnt_load = 1'b1;
          cnt_val  = CNT_W'(SEQ_CYCLES - 1);  // see R14
        end
      end
      HRS_WAIT_HI: begin
        if (cnt_done && RESET_INPUT_N_I) begin
          cnt_load = 1'b1;
          cnt_val  = CNT_W'(END_DLY - 1);  // see R12
        end
      end
      HRS_END: begin
        if (cnt_done) begin
          cnt_load = 1'b1;
          cnt_val  = CNT_W'(ALE_DLY - 1);  // see R13
        end
      end
      default: begin
        cnt_load = 1'b0;
      end
    endcase
  end

  // sequence state
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state_q <= HRS_SEQ;
    end else begin
      case (state_q)
        HRS_RUN: begin
          if (pin_low) begin
            state_q <= HRS_DRAIN;  // see R1
          end
        end
        HRS_DRAIN: begin
          // a running access finishes before the sequence proper starts
          if (cnt_done && !ACCESS_BUSY) begin
            state_q <= HRS_SEQ;  // see R7
          end
        end
        HRS_SEQ: begin
          if (cnt_done && !cnt_load) begin
            state_q <= HRS_WAIT_HI;
          end
        end
        HRS_WAIT_HI: begin
          if (cnt_done && RESET_INPUT_N_I) begin
            state_q <= HRS_END;  // see R9
          end
        end
        HRS_END: begin
          if (cnt_done) begin
            state_q <= HRS_RUN;
          end
        end
        default: begin
          state_q <= HRS_SEQ;
        end
      endcase
    end
  end

  // pin drive during the internal sequence
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= (state_q == HRS_DRAIN && cnt_done && !ACCESS_BUSY) ||
                 (state_q == HRS_SEQ && !cnt_done);  // see R8
    end
  end

  // core reset, hold cancel and reset vector
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      core_q        <= '{reset_active: 1'b1, fetch_start: 1'b0, fetch_addr: RESET_VECTOR};
      hold_cancel_q <= 1'b0;
    end else begin
      hold_cancel_q <= pin_low && HOLD_PENDING && state_q != HRS_END;  // see R7
      core_q.fetch_addr  <= RESET_VECTOR;  // see R4
      core_q.fetch_start <= (state_q == HRS_END) && cnt_done;  // see R4
      if (state_q == HRS_RUN && pin_low) begin
        core_q.reset_active <= 1'b1;  // see R1
      end else if (state_q == HRS_END && cnt_done) begin
        core_q.reset_active <= 1'b0;  // see R12
      end
    end
  end

  // address latch enable delay after internal reset end
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ale_pend_q <= 1'b0;
      ale_q      <= 1'b0;
    end else begin
      if (state_q == HRS_END && cnt_done) begin
        ale_pend_q <= 1'b1;
      end else if (ale_pend_q && cnt_done) begin
        ale_pend_q <= 1'b0;
      end
      if (core_q.reset_active) begin
        ale_q <= 1'b0;
      end else if (ale_pend_q && cnt_done) begin
        ale_q <= 1'b1;  // see R13
      end
    end
  end

  // reset output, io enable, pull-ups and strap capture
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rout_n_q <= 1'b0;
      io_en_q  <= 1'b0;
      pull_q   <= 1'b1;
      cfg_q    <= CFG_RESET;
    end else begin
      pull_q <= core_q.reset_active;  // see R3
      if (core_q.reset_active) begin
        rout_n_q <= 1'b0;  // see R5
        io_en_q  <= 1'b0;  // see R6
        cfg_q    <= STARTUP_CONFIG_PORT;  // see R3
      end else begin
        if (END_OF_INIT_INSTRUCTION) begin
          rout_n_q <= 1'b1;  // see R5
        end
        if (IO_ENABLE_SW) begin
          io_en_q <= 1'b1;  // see R6
        end
      end
    end
  end

  assign RESET_INPUT_N_O  = 1'b0;
  assign RESET_INPUT_N_OE = drive_q;
  assign RESET_OUTPUT_N   = rout_n_q;
  assign CORE_RESET       = core_q.reset_active;
  assign HOLD_CANCEL      = hold_cancel_q;
  assign FETCH_START      = core_q.fetch_start;
  assign FETCH_ADDR       = core_q.fetch_addr;
  assign IO_ENABLE        = io_en_q;
  assign ALE              = ale_q;
  assign CONFIG_PULLUP_EN = pull_q;
  assign STARTUP_CONFIG   = cfg_q;

  // assertions
  a_entry_reset: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R1
    (state_q == HRS_RUN && pin_low) |=> CORE_RESET)
    else $error("core reset not entered on pin low");
  a_pullup_on: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R3
    CORE_RESET |=> CONFIG_PULLUP_EN)
    else $error("pull-ups off during reset");
  a_vector_zero: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R4
    FETCH_START |-> (FETCH_ADDR == RESET_VECTOR) && !CORE_RESET)
    else $error("fetch not at reset vector");
  a_rout_held: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R5
    $rose(RESET_OUTPUT_N) |-> !CORE_RESET && $past(END_OF_INIT_INSTRUCTION))
    else $error("reset output released early");
  a_io_idle: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R6
    $rose(IO_ENABLE) |-> $past(IO_ENABLE_SW))
    else $error("io enabled without software");
  a_drain_wait: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R7
    (state_q == HRS_DRAIN && ACCESS_BUSY) |=> state_q == HRS_DRAIN)
    else $error("sequence started during access");
  a_pin_drive: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R8
    $rose(RESET_INPUT_N_OE) |-> ##1 RESET_INPUT_N_OE [*8])
    else $error("pin drive too short");
  a_stay_reset: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R9
    (state_q == HRS_WAIT_HI && pin_low) |=> state_q == HRS_WAIT_HI)
    else $error("left reset with pin low");
  // drive is registered: it shows one edge after the drain count ends
  a_start_delay: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R11
    (state_q == HRS_RUN && pin_low && !ACCESS_BUSY) ##1 !ACCESS_BUSY [*8]
    |=> RESET_INPUT_N_OE)
    else $error("sequence start delay wrong");
  a_end_delay: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R12
    (state_q == HRS_WAIT_HI && cnt_done && RESET_INPUT_N_I) |-> ##6 $fell(CORE_RESET))
    else $error("internal reset end delay wrong");
  a_ale_delay: assert property (@(posedge CLK_SYS) disable iff (SRST)  // see R13
    $fell(CORE_RESET) |-> ##8 $rose(ALE))
    else $error("ale not 8 cycles after reset end");
  c_warm_reset: cover property (@(posedge CLK_SYS) disable iff (SRST)
    state_q == HRS_RUN ##1 state_q == HRS_DRAIN);
  c_pin_held: cover property (@(posedge CLK_SYS) disable iff (SRST)
    state_q == HRS_WAIT_HI && pin_low);
  c_end_of_init_instruction: cover property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(RESET_OUTPUT_N));

endmodule

// *** hrs_top_bench.sv ***
// Purpose: self-checking bench for the reset sequencer
// Assumes: short sequence length to keep the run brief
// Notes:   fetch starts are compared against a queue of expected results
`timescale 1ns/100ps
module hrs_top_bench
  import hrs_pkg::*;
;
  localparam int unsigned SEQ = 16;
  logic              clk_sys  = 1'b0;
  logic              srst     = 1'b1;
  logic              eoi      = 1'b0;
  logic              busy     = 1'b0;
  logic              hold     = 1'b0;
  logic              io_sw    = 1'b0;
  logic              pull_req = 1'b0;
  logic [CFG_W-1:0]  mask     = '0;
  logic              pin, oe, od, rst_out_n, core_rst, hold_cx, fstart, io_en, ale, pu_en;
  logic [ADDR_W-1:0] faddr;
  logic [CFG_W-1:0]  straps, cfg;
  logic [39:0]       exp_q[$];
  int                mismatches  = 0;
  int                comparisons = 0;
  int                seed        = 98;
  int                cycles      = 0;

  initial forever #20 clk_sys = ~clk_sys;

  hrs_partner part (.clk(clk_sys), .pull_req(pull_req), .pulldown_mask(mask), .dev_oe(oe),
    .dev_o(od), .pullup_en(pu_en), .pin(pin), .straps(straps));

  hrs_top #(.SEQ_CYCLES(SEQ)) dut (.CLK_SYS(clk_sys), .SRST(srst), .RESET_INPUT_N_I(pin),
    .RESET_INPUT_N_O(od), .RESET_INPUT_N_OE(oe), .RESET_OUTPUT_N(rst_out_n),
    .END_OF_INIT_INSTRUCTION(eoi), .ACCESS_BUSY(busy), .HOLD_PENDING(hold),
    .IO_ENABLE_SW(io_sw), .CORE_RESET(core_rst), .HOLD_CANCEL(hold_cx), .FETCH_START(fstart),
    .FETCH_ADDR(faddr), .IO_ENABLE(io_en), .ALE(ale), .STARTUP_CONFIG_PORT(straps),
    .CONFIG_PULLUP_EN(pu_en), .STARTUP_CONFIG(cfg));

  task automatic chk_vec(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({39'h0, got}, {39'h0, exp});
  endtask

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  function automatic logic sel(input int k);
    case (k)
      0: return core_rst;
      1: return oe;
      default: return ale;
    endcase
  endfunction

  task automatic wait_for(input int k, input logic v, output int n);
    n = 0;
    while (sel(k) !== v && n < 200) begin
      step();
      n++;
    end
  endtask

  // pin pulse, optional access in flight, then the full sequence and release
  task automatic warm(input int b);
    int n;
    int m;
    mask = 16'($random(seed));
    busy = (b > 0);
    hold = 1'b1;
    pull_req = 1'b1;
    step();
    pull_req = 1'b0;
    step();
    chk_bit(core_rst, 1'b1);
    chk_bit(hold_cx, 1'b1);
    step();
    chk_bit(pu_en, 1'b1);
    chk_bit(io_en, 1'b0);
    repeat (b) step();
    chk_bit(oe, 1'b0);
    busy = 1'b0;
    hold = 1'b0;
    wait_for(1, 1'b1, n);
    if (b == 0) chk_bit(n + 3 >= START_DLY_MIN + 1 && n + 3 <= START_DLY_MAX + 1, 1'b1);
    m = 0;
    while (oe === 1'b1 && m < 2000) begin
      chk_bit(pin, 1'b0);
      chk_bit(od, 1'b0);
      step();
      m++;
    end
    chk_vec(40'(m), 40'(SEQ));
    while (pin === 1'b0 && m < 2000) begin
      chk_bit(core_rst, 1'b1);
      step();
      m++;
    end
    exp_q.push_back({RESET_VECTOR, ~mask});
    wait_for(0, 1'b0, n);
    chk_vec(40'(n), 40'(END_DLY + 1));
    chk_bit(rst_out_n, 1'b0);
    wait_for(2, 1'b1, n);
    chk_vec(40'(n), 40'(ALE_DLY));
    $display("warm reset test done, busy %0d", b);
  endtask

  // a fetch start is the one result that carries data
  always @(negedge clk_sys) begin
    if (fstart === 1'b1) begin
      if (exp_q.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_vec({faddr, cfg}, exp_q.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    int n;
    mask = 16'($random(seed));
    io_sw = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_bit(core_rst, 1'b1);
    chk_bit(pu_en, 1'b1);
    chk_bit(io_en, 1'b0);
    exp_q.push_back({RESET_VECTOR, ~mask});
    srst = 1'b0;
    io_sw = 1'b0;
    wait_for(0, 1'b0, n);
    wait_for(2, 1'b1, n);
    chk_vec(40'(n), 40'(ALE_DLY));
    chk_bit(io_en, 1'b0);
    chk_bit(rst_out_n, 1'b0);
    io_sw = 1'b1;
    eoi = 1'b1;
    step();
    eoi = 1'b0;
    step();
    chk_bit(rst_out_n, 1'b1);
    chk_bit(io_en, 1'b1);
    $display("cold reset test done");
    warm(0);
    warm(20 + ($random(seed) & 7));
    step();
    chk_bit(exp_q.size() == 0, 1'b1);
    summarize();
  end
endmodule
